/* File: hw/g2d_pkg.sv */
// Constants and types shared by the 2D engine control block.
package g2d_pkg;
  localparam logic [31:0] G2D_ADDR_TRIGGER = 32'hb000b000;
  localparam logic [31:0] G2D_ADDR_SCALE = 32'hb000b008;
  localparam logic [31:0] G2D_ADDR_ROTATE = 32'hb000b00c;
  localparam logic [31:0] G2D_ADDR_IRQ = 32'hb000b010;
  localparam logic [31:0] G2D_ADDR_PATTERN = 32'hb000b014;
  localparam logic [31:0] G2D_ADDR_STEPS = 32'hb000b018;
  localparam logic [31:0] G2D_ADDR_INIT = 32'hb000b01c;
  localparam logic [31:0] G2D_ADDR_CTRL = 32'hb000b020;
  localparam logic [31:0] G2D_ADDR_BG = 32'hb000b024;
  localparam logic [31:0] G2D_RESET_WORD = 32'h00000000;
  localparam logic [31:0] G2D_MASK_ROTATE = 32'h07ff07ff;
  localparam logic [31:0] G2D_MASK_PATTERN = 32'h0fffffff;
  localparam logic [31:0] G2D_MASK_STEPS = 32'h3fff3fff;
  localparam logic [31:0] G2D_MASK_INIT = 32'h3fff07ff;
  localparam logic [31:0] G2D_MASK_BG = 32'h00ffffff;
  localparam logic [1:0] G2D_CMD_NOP = 2'h0;
  localparam logic [1:0] G2D_CMD_BLIT = 2'h1;
  localparam logic [1:0] G2D_CMD_LINE = 2'h2;
  localparam logic [1:0] G2D_CMD_BORDER = 2'h3;
  localparam logic [1:0] G2D_KEY_OFF = 2'h0;
  localparam logic [1:0] G2D_KEY_MONO = 2'h1;
  localparam logic [1:0] G2D_KEY_COLOUR = 2'h2;

  typedef struct packed {
    logic [7:0] boolean_mix_code;
    logic [1:0] command;
    logic alpha_en;
    logic line_style_en;
    logic line_draw;
    logic final_pixel_skip;
    logic irq_en;
    logic xy_addressing_sel;
    logic [1:0] keying_kind;
    logic mono_key_input;
    logic colour_key_source;
    logic colour_key_polarity;
    logic dest_advance_enable;
    logic clip_gate;
    logic clip_inside_outside;
    logic source_kind;
    logic [1:0] source_origin;
    logic pattern_kind;
    logic [2:0] octant;
    logic dest_memory_sel;
  } g2d_ctrl_t;

  typedef struct packed {
    logic [7:0] vert_scale_numer;
    logic [7:0] vert_scale_denom;
    logic [7:0] horiz_scale_numer;
    logic [7:0] horiz_scale_denom;
  } g2d_scale_t;

  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } g2d_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } g2d_apb_rsp_t;

  typedef struct packed {
    logic [31:0] pattern;
    logic [31:0] source;
    logic [31:0] dest;
  } g2d_pix_t;

  typedef struct packed {
    logic step;
    logic diag;
    logic draw;
    logic last;
  } g2d_line_step_t;

  typedef enum logic [1:0] {
    G2D_IDLE, G2D_LINE, G2D_BLIT, G2D_FINISH
  } g2d_state_t;
endpackage : g2d_pkg

/* File: hw/g2d_engine_ctrl.sv */
// Register file, job sequencer and line stepper of the 2D engine.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module g2d_engine_ctrl
  import g2d_pkg::*;
#(
  parameter int DIM_W = 11
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire g2d_apb_req_t apb_in,
  output g2d_apb_rsp_t apb_out,
  input wire logic [DIM_W-1:0] src_width_in,
  input wire logic [DIM_W-1:0] src_height_in,
  input wire g2d_pix_t pix_in,
  input wire logic mono_src_bit_in,
  input wire logic mono_pat_bit_in,
  input wire logic src_key_match_in,
  input wire logic dst_key_match_in,
  input wire logic clip_inside_in,
  input wire logic blit_done_in,
  output g2d_ctrl_t ctrl_out,
  output logic [DIM_W-1:0] scaled_width_out,
  output logic [DIM_W-1:0] scaled_height_out,
  output logic [10:0] rotate_x_out,
  output logic [10:0] rotate_y_out,
  output logic [27:0] pattern_base_out,
  output logic [23:0] background_out,
  output logic [31:0] mix_out,
  output logic pixel_write_out,
  output g2d_line_step_t line_out,
  output logic x_neg_out,
  output logic y_neg_out,
  output logic y_major_out,
  output logic busy_out,
  output logic job_done_out,
  output logic dest_update_out,
  output logic irq_out
);

  typedef struct packed {
    g2d_ctrl_t ctrl;
    g2d_scale_t scale;
    logic [31:0] rotate;
    logic [31:0] pattern;
    logic [31:0] steps;
    logic [31:0] init;
    logic [31:0] bg;
    logic go;
    logic irq;
    g2d_state_t state;
    logic [13:0] err;
    logic [10:0] cnt;
    g2d_line_step_t line;
    logic job_done;
    logic dest_upd;
    logic [DIM_W-1:0] sw;
    logic [DIM_W-1:0] sh;
    logic [31:0] mix;
  } g2d_regs_t;

  g2d_regs_t q;
  g2d_regs_t d;

  logic wr;
  logic rd_acc;
  logic known;
  logic done_now;
  logic diag_now;
  logic [13:0] diag_inc;
  logic [13:0] axial_inc;
  logic [DIM_W+7:0] prod_w;
  logic [DIM_W+7:0] prod_h;
  logic [DIM_W+7:0] quot_w;
  logic [DIM_W+7:0] quot_h;
  logic opaque;
  logic clip_ok;
  logic [31:0] rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  assign wr = apb_in.psel & apb_in.penable & apb_in.pwrite;
  assign rd_acc = apb_in.psel & apb_in.penable;

  always_comb begin
    known = 1'b1;
    rdata = G2D_RESET_WORD;
    case (apb_in.paddr)
      G2D_ADDR_TRIGGER: rdata = {31'h0, q.go};
      G2D_ADDR_SCALE: rdata = q.scale;
      G2D_ADDR_ROTATE: rdata = q.rotate;
      G2D_ADDR_IRQ: rdata = {31'h0, q.irq};
      G2D_ADDR_PATTERN: rdata = q.pattern;
      G2D_ADDR_STEPS: rdata = q.steps;
      G2D_ADDR_INIT: rdata = q.init;
      G2D_ADDR_CTRL: rdata = q.ctrl;
      G2D_ADDR_BG: rdata = q.bg;
      default: known = 1'b0;
    endcase
  end

  assign apb_out.prdata = rdata;
  assign apb_out.pready = 1'b1;
  assign apb_out.pslverr = rd_acc & ~known;

  ////////////////////////////////////////////////////////////////////////////
  // Line arithmetic and scaling.

  assign diag_inc = q.steps[29:16];
  assign axial_inc = q.steps[13:0];
  // Diagonal only on a strictly positive error term.
  assign diag_now = ~q.err[13] & (q.err != 14'h0);
  assign prod_w = src_width_in * q.scale.horiz_scale_numer;
  assign prod_h = src_height_in * q.scale.vert_scale_numer;
  // A zero denominator passes the size through unscaled.
  assign quot_w = (q.scale.horiz_scale_denom == 8'h0) ?
    {8'h0, src_width_in} :
    prod_w / {{DIM_W{1'b0}}, q.scale.horiz_scale_denom};
  assign quot_h = (q.scale.vert_scale_denom == 8'h0) ?
    {8'h0, src_height_in} :
    prod_h / {{DIM_W{1'b0}}, q.scale.vert_scale_denom};

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    d = q;
    done_now = 1'b0;
    d.job_done = 1'b0;
    d.dest_upd = 1'b0;
    d.line = '0;
    d.sw = quot_w[DIM_W-1:0];
    d.sh = quot_h[DIM_W-1:0];
    for (int i = 0; i < 32; i++) begin
      d.mix[i] = q.ctrl.boolean_mix_code[{pix_in.pattern[i],
        pix_in.source[i], pix_in.dest[i]}];
    end
    if (wr) begin
      case (apb_in.paddr)
        G2D_ADDR_SCALE: d.scale = apb_in.pwdata;
        G2D_ADDR_ROTATE: d.rotate = apb_in.pwdata & G2D_MASK_ROTATE;
        G2D_ADDR_PATTERN: d.pattern = apb_in.pwdata & G2D_MASK_PATTERN;
        G2D_ADDR_STEPS: d.steps = apb_in.pwdata & G2D_MASK_STEPS;
        G2D_ADDR_INIT: d.init = apb_in.pwdata & G2D_MASK_INIT;
        G2D_ADDR_CTRL: d.ctrl = apb_in.pwdata;
        G2D_ADDR_BG: d.bg = apb_in.pwdata & G2D_MASK_BG;
        default: d.go = q.go;
      endcase
    end
    case (q.state)
      G2D_IDLE: begin
        if (wr && apb_in.paddr == G2D_ADDR_TRIGGER && apb_in.pwdata[0]) begin
          d.go = 1'b1;
          case (q.ctrl.command)
            G2D_CMD_LINE: begin
              d.state = G2D_LINE;
              d.err = q.init[29:16];
              d.cnt = q.init[10:0];
            end
            G2D_CMD_BLIT: d.state = G2D_BLIT;
            G2D_CMD_BORDER: d.state = G2D_BLIT;
            default: d.state = G2D_FINISH;
          endcase
        end
      end
      G2D_LINE: begin
        d.line.step = 1'b1;
        d.line.diag = diag_now;
        d.line.last = (q.cnt == 11'h0);
        d.line.draw = q.ctrl.line_draw &
          ~((q.cnt == 11'h0) & q.ctrl.final_pixel_skip);
        if (diag_now) begin
          d.err = q.err + diag_inc;
        end else begin
          d.err = q.err + axial_inc;
        end
        if (q.cnt == 11'h0) begin
          done_now = 1'b1;
        end else begin
          d.cnt = q.cnt - 11'h1;
        end
      end
      G2D_BLIT: begin
        if (blit_done_in) begin
          done_now = 1'b1;
          d.dest_upd = q.ctrl.dest_advance_enable &
            (q.ctrl.command == G2D_CMD_BLIT);
        end
      end
      G2D_FINISH: done_now = 1'b1;
      default: d.state = G2D_IDLE;
    endcase
    if (done_now) begin
      d.state = G2D_IDLE;
      d.go = 1'b0;
      d.job_done = 1'b1;
    end
    // A completion in the cycle of a clearing write keeps the flag set.
    d.irq = (q.irq & ~(wr && apb_in.paddr == G2D_ADDR_IRQ &&
      apb_in.pwdata[0])) | done_now;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel gating from keying and clipping.

  always_comb begin
    case (q.ctrl.keying_kind)
      G2D_KEY_MONO: opaque = q.ctrl.mono_key_input ?
        mono_pat_bit_in : mono_src_bit_in;
      G2D_KEY_COLOUR: opaque = (q.ctrl.colour_key_source ?
        dst_key_match_in : src_key_match_in) ==
        q.ctrl.colour_key_polarity;
      default: opaque = 1'b1;
    endcase
  end

  assign clip_ok = ~q.ctrl.clip_gate |
    (clip_inside_in ^ q.ctrl.clip_inside_outside);
  assign pixel_write_out = opaque & clip_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Alpha, style, addressing, source origin and memory bits pass out here.
  assign ctrl_out = q.ctrl;
  assign scaled_width_out = q.sw;
  assign scaled_height_out = q.sh;
  assign rotate_x_out = q.rotate[10:0];
  assign rotate_y_out = q.rotate[26:16];
  assign pattern_base_out = q.pattern[27:0];
  assign background_out = q.bg[23:0];
  assign mix_out = q.mix;
  assign line_out = q.line;
  assign x_neg_out = q.ctrl.octant[2];
  assign y_neg_out = q.ctrl.octant[1];
  assign y_major_out = q.ctrl.octant[0];
  assign busy_out = q.go;
  assign job_done_out = q.job_done;
  assign dest_update_out = q.dest_upd;
  assign irq_out = q.irq & q.ctrl.irq_en;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_nop_start;
    q.state == G2D_IDLE && wr && apb_in.paddr == G2D_ADDR_TRIGGER &&
      apb_in.pwdata[0] && q.ctrl.command == G2D_CMD_NOP;
  endsequence

  sequence s_nop_finish;
    q.go ##1 (job_done_out && !q.go);
  endsequence

  AST_NOP_COMPLETES: assert property (
    s_nop_start |=> s_nop_finish)
    else $error("No-op job did not finish in two cycles.");

  AST_TRIGGER_CLEARS: assert property (
    $rose(job_done_out) |-> !q.go && q.state == G2D_IDLE)
    else $error("Trigger still set after completion.");

  AST_STATUS_SETS: assert property (
    job_done_out |-> q.irq)
    else $error("Completion did not set the status flag.");

  AST_STATUS_CLEARS: assert property (
    (wr && apb_in.paddr == G2D_ADDR_IRQ && apb_in.pwdata[0] &&
      !done_now) |=> !q.irq)
    else $error("Writing one did not clear the status flag.");

  AST_IRQ_RAISED: assert property (
    (job_done_out && q.ctrl.irq_en) |-> irq_out)
    else $error("Enabled completion did not raise the interrupt.");

  AST_DIAG_STEP: assert property (
    (q.state == G2D_LINE && diag_now) |=>
      line_out.step && line_out.diag &&
      q.err == $past(q.err) + $past(diag_inc))
    else $error("Positive error did not step diagonally.");

  AST_AXIAL_STEP: assert property (
    (q.state == G2D_LINE && !diag_now) |=>
      line_out.step && !line_out.diag &&
      q.err == $past(q.err) + $past(axial_inc))
    else $error("Non-positive error did not step axially.");

  AST_LINE_END: assert property (
    (q.state == G2D_LINE && q.cnt == 11'h0) |=>
      line_out.last && job_done_out ##1 !line_out.step)
    else $error("Line did not end after its final pixel.");

  AST_LAST_SKIP: assert property (
    (line_out.step && line_out.last && q.ctrl.final_pixel_skip)
      |-> !line_out.draw)
    else $error("Final pixel drawn while skip is set.");

  AST_AUTO_ADVANCE: assert property (
    (q.state == G2D_BLIT && blit_done_in && q.ctrl.dest_advance_enable &&
      q.ctrl.command == G2D_CMD_BLIT) |=> dest_update_out && job_done_out)
    else $error("Destination not advanced at block copy end.");

  AST_CLIP_DROP: assert property (
    (q.ctrl.clip_gate && clip_inside_in == q.ctrl.clip_inside_outside)
      |-> !pixel_write_out)
    else $error("Clipped pixel was written.");

  sequence s_line_start;
    q.state == G2D_IDLE && wr && apb_in.paddr == G2D_ADDR_TRIGGER &&
      apb_in.pwdata[0] && q.ctrl.command == G2D_CMD_LINE;
  endsequence

  sequence s_line_loaded;
    q.state == G2D_LINE && busy_out && q.err == $past(q.init[29:16]) &&
      q.cnt == $past(q.init[10:0]);
  endsequence

  AST_LINE_LOAD: assert property (
    s_line_start |=> s_line_loaded)
    else $error("Line job did not load its error term and count.");

  AST_STATUS_HOLDS: assert property (
    (q.irq && !(wr && apb_in.paddr == G2D_ADDR_IRQ && apb_in.pwdata[0]))
      |=> q.irq)
    else $error("Status flag dropped without a clearing write.");

  AST_BLIT_WAITS: assert property (
    (q.state == G2D_BLIT && !blit_done_in) |=> busy_out && !job_done_out)
    else $error("Block copy ended before the memory side finished.");

  AST_UNITY_WIDTH: assert property (
    (q.scale.horiz_scale_denom != 8'h0 &&
      q.scale.horiz_scale_numer == q.scale.horiz_scale_denom) |=>
      scaled_width_out == $past(src_width_in))
    else $error("Unity horizontal factor changed the width.");

  AST_UNITY_HEIGHT: assert property (
    (q.scale.vert_scale_denom != 8'h0 &&
      q.scale.vert_scale_numer == q.scale.vert_scale_denom) |=>
      scaled_height_out == $past(src_height_in))
    else $error("Unity vertical factor changed the height.");

endmodule : g2d_engine_ctrl

`default_nettype wire

/* File: dv/g2d_mem_model.sv */
// Memory-side model that ends block copy and border jobs.
`timescale 1ns/1ps
`default_nettype none

module g2d_mem_model
  import g2d_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire g2d_ctrl_t ctrl_in,
  input wire logic busy_in,
  input wire logic slow_in,
  output logic blit_done_out
);
  logic [3:0] wait_q;

  // The memory side finishes only copy and border jobs, after one or seven
  // cycles, and lowers its done pulse after a single cycle.
  always_ff @(posedge clk_in) begin
    if (srst_in || !busy_in || blit_done_out) begin
      wait_q <= 4'h0;
      blit_done_out <= 1'b0;
    end else if (ctrl_in.command inside {G2D_CMD_BLIT, G2D_CMD_BORDER}) begin
      wait_q <= wait_q + 4'h1;
      blit_done_out <= (wait_q == (slow_in ? 4'h6 : 4'h0));
    end
  end
endmodule : g2d_mem_model

`default_nettype wire

/* File: dv/graphics_2d_engine_control_bench.sv */
// Self-checking bench for the 2D engine control block.
`timescale 1ns/1ps
`default_nettype none

module graphics_2d_engine_control_bench;
  import g2d_pkg::*;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  g2d_apb_req_t apb_q = '0;
  g2d_apb_rsp_t apb_rsp;
  logic [10:0] width_q = 11'h064;
  logic [10:0] height_q = 11'h0c8;
  g2d_pix_t pix_q = '0;
  logic [4:0] side_q = 5'h00;
  logic slow_q = 1'b0;
  logic blit_done;
  g2d_ctrl_t ctrl;
  logic [10:0] sc_w, sc_h, rot_x, rot_y;
  logic [31:0] mix;
  logic [27:0] pat;
  logic [23:0] bgc;
  logic pix_wr, xn, yn, ym;
  g2d_line_step_t line;
  logic busy, job_done, dest_update, irq;
  logic [31:0] rdat;
  logic rerr;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;

  g2d_engine_ctrl dut (.clk_in(clk_in), .srst_in(srst_in), .apb_in(apb_q),
    .apb_out(apb_rsp), .src_width_in(width_q), .src_height_in(height_q),
    .pix_in(pix_q), .mono_src_bit_in(side_q[4]), .mono_pat_bit_in(side_q[3]),
    .src_key_match_in(side_q[2]), .dst_key_match_in(side_q[1]),
    .clip_inside_in(side_q[0]), .blit_done_in(blit_done), .ctrl_out(ctrl),
    .scaled_width_out(sc_w), .scaled_height_out(sc_h), .rotate_x_out(rot_x),
    .rotate_y_out(rot_y), .pattern_base_out(pat), .background_out(bgc),
    .mix_out(mix), .pixel_write_out(pix_wr), .line_out(line), .x_neg_out(xn),
    .y_neg_out(yn), .y_major_out(ym), .busy_out(busy),
    .job_done_out(job_done), .dest_update_out(dest_update), .irq_out(irq));

  g2d_mem_model model (.clk_in(clk_in), .srst_in(srst_in), .ctrl_in(ctrl),
    .busy_in(busy), .slow_in(slow_q), .blit_done_out(blit_done));

  initial begin
    forever #12.5 clk_in = ~clk_in;
  end

  ////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic apb(input logic [31:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk_in);
    apb_q.paddr <= a;
    apb_q.pwrite <= w;
    apb_q.pwdata <= d;
    apb_q.psel <= 1'b1;
    apb_q.penable <= 1'b0;
    @(posedge clk_in);
    apb_q.penable <= 1'b1;
    @(posedge clk_in);
    while (apb_rsp.pready !== 1'b1) @(posedge clk_in);
    rdat = apb_rsp.prdata;
    rerr = apb_rsp.pslverr;
    apb_q.psel <= 1'b0;
    apb_q.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [31:0] a);
    apb(a, 1'b0, 32'h00000000);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick

  ////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] a [9];
    a = '{G2D_ADDR_TRIGGER, G2D_ADDR_SCALE, G2D_ADDR_ROTATE, G2D_ADDR_IRQ,
          G2D_ADDR_PATTERN, G2D_ADDR_STEPS, G2D_ADDR_INIT, G2D_ADDR_CTRL,
          G2D_ADDR_BG};
    foreach (a[i]) begin
      rd(a[i]);
      chk("reset word", G2D_RESET_WORD, rdat);
    end
    rd(32'hb000b004);
    chk("unmapped err", 32'h00000001, {31'h0, rerr});
    chk("unmapped data", 32'h00000000, rdat);
  endtask : t_reset

  task automatic t_masks();
    logic [31:0] a [5];
    logic [31:0] m [5];
    a = '{G2D_ADDR_ROTATE, G2D_ADDR_PATTERN, G2D_ADDR_STEPS, G2D_ADDR_INIT,
          G2D_ADDR_BG};
    m = '{G2D_MASK_ROTATE, G2D_MASK_PATTERN, G2D_MASK_STEPS, G2D_MASK_INIT,
          G2D_MASK_BG};
    foreach (a[i]) begin
      wr(a[i], 32'hffffffff);
      rd(a[i]);
      chk("masked word", m[i], rdat);
    end
    wr(G2D_ADDR_ROTATE, 32'h01230456);
    tick(2);
    chk("rotate x", 32'h00000456, {21'h0, rot_x});
    chk("rotate y", 32'h00000123, {21'h0, rot_y});
    chk("pattern base", G2D_MASK_PATTERN, {4'h0, pat});
    chk("background", G2D_MASK_BG, {8'h0, bgc});
  endtask : t_masks

  task automatic t_scale();
    wr(G2D_ADDR_SCALE, 32'h01020304);
    tick(2);
    chk("scaled height", 32'h00000064, {21'h0, sc_h});
    chk("scaled width", 32'h0000004b, {21'h0, sc_w});
    wr(G2D_ADDR_SCALE, 32'h05050707);
    tick(2);
    chk("unity height", 32'h000000c8, {21'h0, sc_h});
    chk("unity width", 32'h00000064, {21'h0, sc_w});
  endtask : t_scale

  task automatic t_ctrl();
    logic [31:0] w;
    // Alternate patterns never mark source and pattern both as mono.
    for (int c = 0; c < 4; c++) begin
      w = {8'h5a, c[1:0], c[0] ? 22'h2aaaaa : 22'h155555};
      wr(G2D_ADDR_CTRL, w);
      rd(G2D_ADDR_CTRL);
      chk("ctrl read", w, rdat);
      chk("ctrl out", w, ctrl);
      chk("octant", {29'h0, w[3:1]}, {29'h0, xn, yn, ym});
    end
  endtask : t_ctrl

  task automatic t_mix();
    wr(G2D_ADDR_CTRL, 32'hb4000000);
    pix_q <= '{pattern: 32'hffff0000, source: 32'hff00ff00,
               dest: 32'hf0f0f0f0};
    tick(2);
    // Code b4 read at index pattern, source, destination for each bit.
    chk("mix", 32'hf0ff0f00, mix);
  endtask : t_mix

  task automatic t_gate();
    logic [15:0] c [7];
    logic [4:0] s [7];
    logic e [7];
    c = '{16'h4000, 16'h6000, 16'h8000, 16'h9800, 16'h0200, 16'h0300,
          16'hc000};
    s = '{5'h10, 5'h10, 5'h04, 5'h02, 5'h00, 5'h00, 5'h00};
    e = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    foreach (c[i]) begin
      wr(G2D_ADDR_CTRL, {16'h0000, c[i]});
      side_q <= s[i];
      tick(1);
      chk("pixel write", {31'h0, e[i]}, {31'h0, pix_wr});
    end
  endtask : t_gate

  task automatic t_line();
    int n;
    wr(G2D_ADDR_STEPS, {2'h0, 14'h3ffd, 2'h0, 14'h0004});
    wr(G2D_ADDR_INIT, {2'h0, 14'h0001, 5'h0, 11'h002});
    wr(G2D_ADDR_CTRL, 32'h008e0000);
    wr(G2D_ADDR_TRIGGER, 32'h00000001);
    #1;
    chk("busy", 32'h00000001, {31'h0, busy});
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do tick(1); while (line.step !== 1'b1 && n++ < 10);
      chk("diag", {31'h0, k != 1}, {31'h0, line.diag});
      chk("last", {31'h0, k == 2}, {31'h0, line.last});
      chk("draw", {31'h0, k != 2}, {31'h0, line.draw});
      chk("done", {31'h0, k == 2}, {31'h0, job_done});
    end
    tick(1);
    chk("irq", 32'h00000001, {31'h0, irq});
    rd(G2D_ADDR_TRIGGER);
    chk("trigger", 32'h00000000, rdat);
    wr(G2D_ADDR_IRQ, 32'h00000001);
    rd(G2D_ADDR_IRQ);
    chk("status clear", 32'h00000000, rdat);
    chk("irq clear", 32'h00000000, {31'h0, irq});
  endtask : t_line

  task automatic t_jobs();
    logic [1:0] cmds [3];
    int n;
    cmds = '{G2D_CMD_BLIT, G2D_CMD_BORDER, G2D_CMD_NOP};
    foreach (cmds[i]) begin
      slow_q <= (i == 1);
      wr(G2D_ADDR_CTRL, {8'h00, cmds[i], 22'h000400});
      wr(G2D_ADDR_TRIGGER, 32'h00000001);
      n = 0;
      do tick(1); while (job_done !== 1'b1 && n++ < 20);
      chk("done", 32'h00000001, {31'h0, job_done});
      chk("advance", {31'h0, cmds[i] == G2D_CMD_BLIT},
          {31'h0, dest_update});
      tick(1);
      chk("irq gated", 32'h00000000, {31'h0, irq});
      rd(G2D_ADDR_IRQ);
      chk("status", 32'h00000001, rdat);
      rd(G2D_ADDR_TRIGGER);
      chk("trigger", 32'h00000000, rdat);
      wr(G2D_ADDR_IRQ, 32'h00000001);
    end
  endtask : t_jobs

  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_in);
    srst_in <= 1'b0;
    t_reset();
    t_masks();
    t_scale();
    t_ctrl();
    t_mix();
    t_gate();
    t_line();
    t_jobs();
    finish_test();
  end
endmodule : graphics_2d_engine_control_bench

`default_nettype wire
